// File: hw/hrs_homing_sequencer.sv
// homing reference sequencer with wishbone register slave
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
// Functional notes
// [R1] shift reference selectable, default encoder index
// [R2] home lies offset away along homing direction
// [R3] interrupt captures on event; switches detect level
// [R4] slowdown reference selectable, default home switch
// [R5] index shift: creep at slowdown, offset at index
// [R6] index slowdown: start creeping, first index starts offset
// [R7] home switch qualified rising or trailing edge
// [R8] home offset 0 to 2000000000, default 1000
// [R9] creep reversal backs off then approaches creeping
// [R10] completion loads home coordinate preset into position
// [R11] complete while position within window; zero always
// [R12] travel limit decelerates over configured ramp time
// [R13] stop action halts homing under torque limit
// [R14] reverse action turns at first limit, continues
// [R15] start input off-to-on moves in start direction
// [R16] limit or stopper reference homes away from it
// [R17] power-class settings take effect only at apply
module hrs_homing_sequencer import hrs_pkg::*; #(
  parameter int unsigned DECEL_TICK_CYCLES = DECEL_TICK_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic homing_start_input_i,
  input wire logic home_switch_i,
  input wire logic forward_travel_limit_i,
  input wire logic reverse_travel_limit_i,
  input wire logic index_pulse_i,
  input wire logic capture_input_i,
  input wire logic stopper_detect_i,
  input wire logic [31:0] position_i,
  output logic motion_run_o,
  output logic motion_reverse_o,
  output logic creep_speed_o,
  output logic ot_decel_o,
  output logic torque_stop_o,
  output logic position_load_o,
  output logic [31:0] position_load_value_o,
  output logic homing_complete_o,
  output logic homing_busy_o,
  output logic irq_o
);
  hrs_pins_t pins_raw, pin_lvl, pin_rise, pin_fall;
  hrs_cfg_t cfg_pend, cfg;
  hrs_state_t state;
  hrs_irq_t irq_stat, irq_mask, irq_ev, irq_clr;
  hrs_status_t status;
  logic [31:0] offset, preset, window, cap_pos, rd_data, wr_merged;
  logic [DECEL_W-1:0] decel;
  logic home_dir, ot_seen, homed, timer_load, decel_done;
  logic bus_req, wr_en, abort_cmd, apply_cmd;
  logic sw_event, shift_hit, slow_hit, ref_level, fwd_is_ref, rev_is_ref;
  logic moving, ot_hit, detect_dir, idx_creep, reached;
  logic signed [32:0] pos_ext, target, diff;
  logic [32:0] mag;

  assign pins_raw = '{stopper: stopper_detect_i, capture: capture_input_i,
                      index: index_pulse_i, rev_ot: reverse_travel_limit_i,
                      fwd_ot: forward_travel_limit_i, home_sw: home_switch_i,
                      start: homing_start_input_i};

  hrs_sync_edge #(.W(PIN_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(pins_raw),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  hrs_decel_timer #(.TICK_CYCLES(DECEL_TICK_CYCLES)) u_decel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .units_i(decel),
    .busy_o(),
    .done_o(decel_done)
  );

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus: ack one cycle after the request, write takes effect at the ack edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_en = bus_req & wb_we_i & wb_ack_o;
  assign wr_merged = merge_sel(rd_data, wb_dat_i, wb_sel_i);
  assign abort_cmd = wr_en && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_ABORT_BIT];
  assign apply_cmd = wr_en && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_APPLY_BIT];
  assign irq_clr = (wr_en && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) ?
                   hrs_irq_t'(wb_dat_i[IRQ_W-1:0]) : '0;

  always_comb begin
    status = '{torque_stop: torque_stop_o, ot_decel: ot_decel_o, complete: homing_complete_o,
               homed: homed, busy: homing_busy_o, state: state};
    rd_data = '0;
    case (wb_adr_i)
      ADDR_CFG: rd_data[CFG_W-1:0] = cfg_pend;
      ADDR_ACT_CFG: rd_data[CFG_W-1:0] = cfg;
      ADDR_OFFSET: rd_data = offset;
      ADDR_PRESET: rd_data = preset;
      ADDR_WINDOW: rd_data = window;
      ADDR_DECEL: rd_data[DECEL_W-1:0] = decel;
      ADDR_STATUS: rd_data[STATUS_W-1:0] = status;
      ADDR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat;
      ADDR_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask;
      ADDR_CAPTURE: rd_data = cap_pos;
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_pend <= CFG_DEFAULT;
      cfg <= CFG_DEFAULT;
      offset <= OFFSET_DEFAULT;
      preset <= PRESET_DEFAULT;
      window <= WINDOW_DEFAULT;
      decel <= DECEL_DEFAULT;
      irq_mask <= '0;
    end else if (ce_i) begin
      if (apply_cmd && state == ST_IDLE) begin
        cfg <= cfg_pend; // [R17]
      end
      if (wr_en) begin
        case (wb_adr_i)
          ADDR_CFG: cfg_pend <= hrs_cfg_t'(wr_merged[CFG_W-1:0]);
          ADDR_OFFSET: offset <= (wr_merged > RANGE_MAX) ? RANGE_MAX : wr_merged; // [R8]
          ADDR_PRESET: begin
            if ($signed(wr_merged) > $signed(RANGE_MAX)) begin
              preset <= RANGE_MAX;
            end else if ($signed(wr_merged) < $signed(PRESET_MIN)) begin
              preset <= PRESET_MIN;
            end else begin
              preset <= wr_merged;
            end
          end
          ADDR_WINDOW: window <= (wr_merged > RANGE_MAX) ? RANGE_MAX : wr_merged;
          ADDR_DECEL: decel <= (wr_merged > 32'(DECEL_MAX)) ? DECEL_MAX : wr_merged[DECEL_W-1:0];
          ADDR_IRQ_MASK: irq_mask <= hrs_irq_t'(wr_merged[IRQ_W-1:0]);
          default: ;
        endcase
      end
    end
  end

  // reference detection and direction choice
  always_comb begin
    sw_event = cfg.edge_sel ? pin_fall.home_sw : pin_rise.home_sw; // [R7]
    case (cfg.shift_ref) // [R1] [R3]
      SHIFT_SWITCH: shift_hit = sw_event;
      SHIFT_INDEX: shift_hit = pin_rise.index;
      SHIFT_FWD_OT: shift_hit = pin_lvl.fwd_ot;
      SHIFT_REV_OT: shift_hit = pin_lvl.rev_ot;
      SHIFT_CAPTURE: shift_hit = pin_rise.capture;
      SHIFT_STOPPER: shift_hit = pin_lvl.stopper;
      default: shift_hit = 1'b0;
    endcase
    case (cfg.slow_ref) // [R4]
      SLOW_SWITCH: slow_hit = sw_event;
      SLOW_FWD_OT: slow_hit = pin_lvl.fwd_ot;
      SLOW_REV_OT: slow_hit = pin_lvl.rev_ot;
      SLOW_INDEX: slow_hit = pin_rise.index;
      SLOW_STOPPER: slow_hit = pin_lvl.stopper;
      default: slow_hit = 1'b0;
    endcase
    case (cfg.shift_ref)
      SHIFT_SWITCH: ref_level = pin_lvl.home_sw;
      SHIFT_FWD_OT: ref_level = pin_lvl.fwd_ot;
      SHIFT_REV_OT: ref_level = pin_lvl.rev_ot;
      SHIFT_STOPPER: ref_level = pin_lvl.stopper;
      default: ref_level = 1'b0;
    endcase
    case (cfg.shift_ref) // [R16] [R2]
      SHIFT_FWD_OT: detect_dir = 1'b1;
      SHIFT_REV_OT: detect_dir = 1'b0;
      SHIFT_STOPPER: detect_dir = ~motion_reverse_o;
      SHIFT_INDEX: detect_dir = cfg.start_dir;
      default: detect_dir = cfg.post_dir;
    endcase
    idx_creep = cfg.shift_ref == SHIFT_INDEX && cfg.slow_ref == SLOW_INDEX;
    fwd_is_ref = cfg.shift_ref == SHIFT_FWD_OT ||
                 (cfg.shift_ref == SHIFT_INDEX && cfg.slow_ref == SLOW_FWD_OT);
    rev_is_ref = cfg.shift_ref == SHIFT_REV_OT ||
                 (cfg.shift_ref == SHIFT_INDEX && cfg.slow_ref == SLOW_REV_OT);
    moving = state == ST_SEEK || state == ST_CREEP || state == ST_BACKUP;
    ot_hit = moving && ((pin_lvl.fwd_ot && !motion_reverse_o && !fwd_is_ref) ||
                        (pin_lvl.rev_ot && motion_reverse_o && !rev_is_ref));
    pos_ext = $signed({position_i[31], position_i});
    target = home_dir ? $signed({cap_pos[31], cap_pos}) - $signed({1'b0, offset}) :
                        $signed({cap_pos[31], cap_pos}) + $signed({1'b0, offset});
    reached = home_dir ? (pos_ext <= target) : (pos_ext >= target); // [R2]
    diff = pos_ext - $signed({preset[31], preset});
    mag = diff[32] ? 33'(-diff) : 33'(diff);
  end

  // homing sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      motion_run_o <= 1'b0;
      motion_reverse_o <= 1'b0;
      creep_speed_o <= 1'b0;
      torque_stop_o <= 1'b0;
      homing_busy_o <= 1'b0;
      position_load_o <= 1'b0;
      position_load_value_o <= '0;
      home_dir <= 1'b0;
      cap_pos <= '0;
      ot_seen <= 1'b0;
      homed <= 1'b0;
      timer_load <= 1'b0;
      irq_ev <= '0;
    end else if (ce_i) begin
      timer_load <= 1'b0;
      position_load_o <= 1'b0;
      irq_ev <= '0;
      if (abort_cmd && state != ST_IDLE) begin
        state <= ST_IDLE;
        motion_run_o <= 1'b0;
        creep_speed_o <= 1'b0;
        torque_stop_o <= 1'b0;
        homing_busy_o <= 1'b0;
      end else if (ot_hit) begin
        creep_speed_o <= 1'b0;
        ot_seen <= 1'b1;
        if (cfg.ot_action || ot_seen) begin
          state <= ST_CANCEL; // [R13]
          motion_run_o <= 1'b0;
          torque_stop_o <= 1'b1;
          homing_busy_o <= 1'b0;
          irq_ev.cancel <= 1'b1;
        end else begin
          state <= ST_OT_DECEL;
          timer_load <= 1'b1; // [R12]
        end
      end else begin
        case (state)
          ST_IDLE: begin
            if (pin_rise.start) begin
              state <= idx_creep ? ST_CREEP : ST_SEEK; // [R15]
              motion_run_o <= 1'b1;
              motion_reverse_o <= cfg.start_dir;
              creep_speed_o <= idx_creep; // [R6]
              home_dir <= cfg.start_dir;
              homing_busy_o <= 1'b1;
              ot_seen <= 1'b0;
              homed <= 1'b0;
            end
          end
          ST_SEEK: begin
            if (cfg.shift_ref == SHIFT_INDEX) begin
              if (slow_hit) begin
                state <= ST_CREEP; // [R5]
                creep_speed_o <= 1'b1;
              end
            end else if (shift_hit) begin
              home_dir <= detect_dir;
              cap_pos <= position_i; // [R3]
              irq_ev.ref_found <= 1'b1;
              if (cfg.creep_rev) begin
                state <= ST_BACKUP; // [R9]
                motion_reverse_o <= ~detect_dir;
              end else begin
                state <= ST_OFFSET;
                motion_reverse_o <= detect_dir;
                creep_speed_o <= 1'b1;
              end
            end
          end
          ST_BACKUP: begin
            if (!ref_level) begin
              state <= ST_CREEP; // [R9]
              creep_speed_o <= 1'b1;
              motion_reverse_o <= home_dir;
            end
          end
          ST_CREEP: begin
            if (shift_hit) begin
              state <= ST_OFFSET; // [R5]
              home_dir <= detect_dir;
              motion_reverse_o <= detect_dir;
              cap_pos <= position_i;
              irq_ev.ref_found <= 1'b1;
            end
          end
          ST_OFFSET: begin
            if (reached) begin
              state <= ST_FINISH; // [R2]
              motion_run_o <= 1'b0;
              creep_speed_o <= 1'b0;
            end
          end
          ST_FINISH: begin
            state <= ST_IDLE;
            position_load_o <= 1'b1; // [R10]
            position_load_value_o <= preset;
            homed <= 1'b1;
            homing_busy_o <= 1'b0;
            irq_ev.done <= 1'b1;
          end
          ST_OT_DECEL: begin
            if (decel_done) begin
              state <= ST_SEEK; // [R14]
              motion_reverse_o <= ~motion_reverse_o;
            end
          end
          ST_CANCEL: begin
            if (!pin_lvl.start) begin
              state <= ST_IDLE;
              torque_stop_o <= 1'b0;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      homing_complete_o <= 1'b0;
      ot_decel_o <= 1'b0;
    end else if (ce_i) begin
      homing_complete_o <= homed && (window == '0 || mag <= {1'b0, window}); // [R11]
      ot_decel_o <= state == ST_OT_DECEL;
    end
  end

  // sticky events, a new event wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  AST_START_DIR: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    (ce_i && state == ST_IDLE && pin_rise.start && !ot_hit)
      |=> (motion_run_o && motion_reverse_o == $past(cfg.start_dir) && homing_busy_o))
    else $error("start edge did not launch motion in start direction");
  AST_INDEX_CREEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && state == ST_IDLE && pin_rise.start && idx_creep)
      |=> (state == ST_CREEP && creep_speed_o))
    else $error("index slowdown did not start at creep speed");
  AST_SLOW_TO_CREEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (ce_i && state == ST_SEEK && cfg.shift_ref == SHIFT_INDEX && slow_hit && !ot_hit
     && !abort_cmd) |=> (state == ST_CREEP && creep_speed_o && motion_run_o))
    else $error("slowdown reference did not drop to creep");
  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (ce_i && state == ST_CREEP && shift_hit && !ot_hit && !abort_cmd)
      |=> (state == ST_OFFSET && cap_pos == $past(position_i)))
    else $error("reference position not captured");
  AST_PRESET_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (ce_i && state == ST_OFFSET && reached && !abort_cmd && !ot_hit)
      |=> ##1 (!$past(ce_i) || (position_load_o && homed && position_load_value_o == $past(preset))))
    else $error("preset not loaded after homing");
  AST_WINDOW_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (ce_i && homed && window == '0) |=> homing_complete_o)
    else $error("zero window did not hold completion");
  AST_OT_STOP: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (ce_i && ot_hit && cfg.ot_action && !abort_cmd)
      |=> (torque_stop_o && !motion_run_o && state == ST_CANCEL))
    else $error("stop action did not halt homing");
  AST_OT_REVERSE: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (ce_i && state == ST_OT_DECEL && decel_done && !abort_cmd)
      |=> (state == ST_SEEK && motion_reverse_o != $past(motion_reverse_o)))
    else $error("motion did not reverse after limit");
  AST_OT_DECEL: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (ce_i && ot_hit && !cfg.ot_action && !ot_seen && !abort_cmd)
      |=> (state == ST_OT_DECEL && motion_run_o) ##1 (!$past(ce_i) || ot_decel_o))
    else $error("limit did not start deceleration ramp");
  AST_OFFSET_RANGE: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (offset <= RANGE_MAX && window <= RANGE_MAX))
    else $error("distance register out of range");
  AST_POWER_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (cfg != $past(cfg)) |-> $past(apply_cmd && ce_i))
    else $error("active configuration changed without apply");
endmodule // hrs_homing_sequencer

// File: hw/hrs_pkg.sv
// shared constants, register map and types of the homing sequencer
package hrs_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_PRESET = 8'h0C;
  localparam logic [7:0] ADDR_WINDOW = 8'h10;
  localparam logic [7:0] ADDR_DECEL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_CAPTURE = 8'h24;
  localparam logic [7:0] ADDR_ACT_CFG = 8'h28;

  localparam int CTRL_ABORT_BIT = 0;
  localparam int CTRL_APPLY_BIT = 1;

  // shift reference encodings
  localparam logic [2:0] SHIFT_SWITCH = 3'h0;
  localparam logic [2:0] SHIFT_INDEX = 3'h1;
  localparam logic [2:0] SHIFT_FWD_OT = 3'h2;
  localparam logic [2:0] SHIFT_REV_OT = 3'h3;
  localparam logic [2:0] SHIFT_CAPTURE = 3'h4;
  localparam logic [2:0] SHIFT_STOPPER = 3'h5;
  // slowdown reference encodings
  localparam logic [2:0] SLOW_SWITCH = 3'h0;
  localparam logic [2:0] SLOW_FWD_OT = 3'h1;
  localparam logic [2:0] SLOW_REV_OT = 3'h2;
  localparam logic [2:0] SLOW_INDEX = 3'h3;
  localparam logic [2:0] SLOW_STOPPER = 3'h4;

  // distance limits in user units
  localparam logic [31:0] RANGE_MAX = 32'h7735_9400;
  localparam logic [31:0] PRESET_MIN = 32'h88CA_6C00;
  localparam logic [31:0] OFFSET_DEFAULT = 32'h0000_03E8;
  localparam logic [31:0] PRESET_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] WINDOW_DEFAULT = 32'h0000_0000;

  // overtravel deceleration time, in units of 0.1 ms
  localparam int DECEL_W = 20;
  localparam logic [DECEL_W-1:0] DECEL_MAX = 20'hF_423F;
  localparam logic [DECEL_W-1:0] DECEL_DEFAULT = 20'h0_03E8;
  localparam int DECEL_UNIT_NS = 100000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int DECEL_TICK_DEFAULT = (DECEL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEEK = 3'h1,
    ST_CREEP = 3'h3,
    ST_OFFSET = 3'h2,
    ST_FINISH = 3'h6,
    ST_BACKUP = 3'h7,
    ST_OT_DECEL = 3'h5,
    ST_CANCEL = 3'h4
  } hrs_state_t;

  typedef struct packed {
    logic post_dir;
    logic start_dir;
    logic ot_action;
    logic creep_rev;
    logic edge_sel;
    logic [2:0] slow_ref;
    logic [2:0] shift_ref;
  } hrs_cfg_t;
  localparam int CFG_W = $bits(hrs_cfg_t);
  localparam hrs_cfg_t CFG_DEFAULT = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SLOW_SWITCH, SHIFT_INDEX};

  typedef struct packed {
    logic stopper;
    logic capture;
    logic index;
    logic rev_ot;
    logic fwd_ot;
    logic home_sw;
    logic start;
  } hrs_pins_t;
  localparam int PIN_W = $bits(hrs_pins_t);

  typedef struct packed {
    logic ref_found;
    logic cancel;
    logic done;
  } hrs_irq_t;
  localparam int IRQ_W = $bits(hrs_irq_t);

  typedef struct packed {
    logic torque_stop;
    logic ot_decel;
    logic complete;
    logic homed;
    logic busy;
    hrs_state_t state;
  } hrs_status_t;
  localparam int STATUS_W = $bits(hrs_status_t);
endpackage

// File: hw/hrs_sync_edge.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/100ps
module hrs_sync_edge #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      stable <= meta;
      prev <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o = stable & ~prev;
  assign fall_o = ~stable & prev;
endmodule // hrs_sync_edge

// File: hw/hrs_decel_timer.sv
// overtravel deceleration ramp timer counting 0.1 ms units
`timescale 1ns/100ps
module hrs_decel_timer import hrs_pkg::*; #(
  parameter int unsigned TICK_CYCLES = DECEL_TICK_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [DECEL_W-1:0] units_i,
  output logic busy_o,
  output logic done_o
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  logic [DECEL_W-1:0] remain;
  logic [TW-1:0] presc;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      remain <= '0;
      presc <= '0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (load_i) begin
        busy_o <= 1'b1;
        remain <= units_i;
        presc <= '0;
      end else if (busy_o) begin
        if (remain == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else if (presc == TICK_LAST) begin
          presc <= '0;
          remain <= remain - 1'b1; // [R12]
        end else begin
          presc <= presc + 1'b1;
        end
      end
    end
  end

  AST_DECEL_TICK: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (ce_i && busy_o && !load_i && remain != '0 && presc == TICK_LAST)
      |=> (remain == $past(remain) - 1'b1))
    else $error("deceleration unit count did not step");
endmodule // hrs_decel_timer

// File: sim/hrs_motion_model.sv
// behavioural axis model: position counter and encoder index line
`timescale 1ns/100ps
module hrs_motion_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic reverse_i,
  input wire logic creep_i,
  input wire logic load_i,
  input wire logic [31:0] load_value_i,
  output logic [31:0] position_o,
  output logic index_o
);
  logic [31:0] step;
  assign step = creep_i ? 32'h1 : 32'h4;
  // index rises once per 128 units of travel
  assign index_o = position_o[6];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position_o <= '0;
    end else if (load_i) begin
      position_o <= load_value_i;
    end else if (run_i) begin
      position_o <= reverse_i ? position_o - step : position_o + step;
    end
  end
endmodule // hrs_motion_model

// File: sim/test_homing_reference_sequencer.sv
// self-checking bench of the homing sequencer
`timescale 1ns/100ps
module test_homing_reference_sequencer import hrs_pkg::*; ;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic st = 1'b0, sw = 1'b0, fot = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, cap, pos, rdat, ldv, p;
  logic ack, run, rev, creep, tq, ld, cpl, irq, idx, otd, bsy, ce = 1'b1;
  int n_errors = 0, comparisons = 0, n;
  logic [7:0] ra [6] = '{ADDR_CFG, ADDR_OFFSET, ADDR_PRESET, ADDR_WINDOW, ADDR_DECEL, 8'h3C};
  logic [31:0] rx [6] = '{32'h1, OFFSET_DEFAULT, PRESET_DEFAULT, WINDOW_DEFAULT,
    {12'h0, DECEL_DEFAULT}, 32'h0};
  hrs_homing_sequencer #(.DECEL_TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .homing_start_input_i(st), .home_switch_i(sw), .forward_travel_limit_i(fot),
    .reverse_travel_limit_i(1'b0), .index_pulse_i(idx), .capture_input_i(1'b0),
    .stopper_detect_i(1'b0), .position_i(p), .motion_run_o(run), .motion_reverse_o(rev),
    .creep_speed_o(creep), .ot_decel_o(otd), .torque_stop_o(tq), .position_load_o(ld),
    .position_load_value_o(ldv), .homing_complete_o(cpl), .homing_busy_o(bsy), .irq_o(irq));
  hrs_motion_model axis (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .reverse_i(rev),
    .creep_i(creep), .load_i(ld), .load_value_i(ldv), .position_o(p), .index_o(idx));
  initial forever #2.5 clk_i = ~clk_i;
  task end_sim;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(ra[i], 1'b0, 32'h0);
      chk("reset value", q, rx[i]);
    end
    bus(ADDR_OFFSET, 1'b1, 32'hFFFF_FFFF);
    bus(ADDR_OFFSET, 1'b0, 32'h0);
    chk("offset clamp", q, RANGE_MAX);
    bus(ADDR_PRESET, 1'b1, 32'h8000_0000);
    bus(ADDR_PRESET, 1'b0, 32'h0);
    chk("preset clamp", q, PRESET_MIN);
    bus(ADDR_OFFSET, 1'b1, 32'h64);
    bus(ADDR_PRESET, 1'b1, 32'h55);
    st <= 1'b1;
    for (n = 0; n < 99 && run !== 1'b1; n++) @(posedge clk_i);
    chk("run", run, 1'b1);
    chk("direction", rev, 1'b0);
    chk("fast seek", creep, 1'b0);
    chk("busy", bsy, 1'b1);
    repeat (20) @(posedge clk_i);
    sw <= 1'b1;
    for (n = 0; n < 20 && creep !== 1'b1; n++) @(posedge clk_i);
    chk("creep", creep, 1'b1);
    for (n = 0; n < 2000 && ld !== 1'b1; n++) @(posedge clk_i);
    pos = p;
    chk("preset load", ldv, 32'h55);
    bus(ADDR_CAPTURE, 1'b0, 32'h0);
    cap = q;
    // the index line rises where travel crosses 64 modulo 128
    chk("index capture", 32'(cap[6:3] == 4'h8), 32'h1);
    chk("offset travel", 32'(pos - cap - 32'h64 < 32'h8), 32'h1);
    repeat (3) @(posedge clk_i);
    chk("complete", cpl, 1'b1);
    bus(ADDR_WINDOW, 1'b1, 32'h5);
    bus(ADDR_PRESET, 1'b1, 32'h5B);
    repeat (3) @(posedge clk_i);
    chk("outside window", cpl, 1'b0);
    bus(ADDR_PRESET, 1'b1, 32'h59);
    repeat (3) @(posedge clk_i);
    chk("inside window", cpl, 1'b1);
    chk("irq masked", irq, 1'b0);
    bus(ADDR_IRQ_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq done", irq, 1'b1);
    bus(ADDR_IRQ_STAT, 1'b1, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", irq, 1'b0);
    bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk("stat cleared", q & 32'h1, 32'h0);
    st <= 1'b0;
    sw <= 1'b0;
    bus(ADDR_CFG, 1'b1, 32'h101);
    bus(ADDR_ACT_CFG, 1'b0, 32'h0);
    chk("active before apply", q, 32'h1);
    bus(ADDR_CTRL, 1'b1, 32'h2);
    bus(ADDR_ACT_CFG, 1'b0, 32'h0);
    chk("active after apply", q, 32'h101);
    st <= 1'b1;
    for (n = 0; n < 99 && run !== 1'b1; n++) @(posedge clk_i);
    repeat (5) @(posedge clk_i);
    // a low clock enable holds the limit off until it rises again
    fot <= 1'b1;
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("frozen", tq, 1'b0);
    ce <= 1'b1;
    for (n = 0; n < 20 && tq !== 1'b1; n++) @(posedge clk_i);
    chk("torque stop", tq, 1'b1);
    chk("halted", run, 1'b0);
    chk("busy off", bsy, 1'b0);
    st <= 1'b0;
    bus(ADDR_CFG, 1'b1, 32'h19);
    bus(ADDR_DECEL, 1'b1, 32'h2);
    bus(ADDR_CTRL, 1'b1, 32'h2);
    st <= 1'b1;
    for (n = 0; n < 99 && run !== 1'b1; n++) @(posedge clk_i);
    chk("index creep", creep, 1'b1);
    for (n = 0; n < 20 && otd !== 1'b1; n++) @(posedge clk_i);
    chk("ot decel", otd, 1'b1);
    chk("run in ramp", run, 1'b1);
    for (n = 0; n < 99 && rev !== 1'b1; n++) @(posedge clk_i);
    chk("reversed", rev, 1'b1);
    chk("still busy", bsy, 1'b1);
    end_sim;
  end
endmodule // test_homing_reference_sequencer
